// ==== rtl/afe_bias_pkg.sv ====
// constants for the global analog bias and integration bank
package afe_bias_pkg;
    // register addresses and data width
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam logic [7:0] BIAS_POWER_ADDR = 8'h3c;
    localparam logic [7:0] OVERRIDE_ADDR = 8'h54;
    // reset values
    localparam logic [15:0] BIAS_POWER_RST = 16'h3006;
    localparam logic [15:0] OVERRIDE_RST = 16'h0020;
    // field positions
    localparam int LEGACY_CATH_BIT = 9;
    localparam int PWRDN_LSB = 3;
    localparam int PWRDN_W = 6;
    localparam int SECOND_ONE_CH_BIT = 15;
    localparam int FIRST_ONE_CH_BIT = 14;
    localparam int SLEEP_CODE_LSB = 12;
    localparam int SECOND_CODE_LSB = 10;
    localparam int FIRST_CODE_LSB = 8;
    localparam int OVERRIDE_EN_BIT = 7;
    // cathode bias codes
    localparam logic [1:0] CODE_1V8 = 2'h0;
    localparam logic [1:0] CODE_1V3 = 2'h1;
    localparam logic [1:0] CODE_1V55 = 2'h2;
    localparam logic [1:0] CODE_0V0 = 2'h3;
    // powerdown field patterns
    localparam logic [5:0] PWRDN_CH234 = 6'h38;
    localparam logic [5:0] PWRDN_NONE = 6'h00;
    // operating phases
    typedef enum logic [2:0] {
        PH_SLEEP = 3'b001,
        PH_FIRST = 3'b010,
        PH_SECOND = 3'b100
    } phase_t;
endpackage : afe_bias_pkg

// ==== rtl/afe_bias_reg16.sv ====
// one 16-bit register with write strobe and reset value
`timescale 1ns/100ps
module afe_bias_reg16 #(
    parameter logic [15:0] RST_VAL = 16'h0000
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic wr_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] q_o
);
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            q_o <= RST_VAL;
        end else if (wr_i) begin
            q_o <= wdata_i;
        end
    end
endmodule : afe_bias_reg16

// ==== rtl/afe_bias_sel.sv ====
// cathode and anode bias code selection per phase
`timescale 1ns/100ps
module afe_bias_sel (
    input wire logic [2:0] phase_i,
    input wire logic legacy_i,
    input wire logic override_i,
    input wire logic [5:0] codes_i,
    output logic [1:0] cath_o,
    output logic [1:0] anode_o
);
    logic [1:0] legacy_code;
    logic [1:0] phase_code;
    // legacy bit: 0 is 1.3 V, 1 is 1.8 V
    assign legacy_code = legacy_i ? afe_bias_pkg::CODE_1V8
                                  : afe_bias_pkg::CODE_1V3;
    always_comb begin
        case (phase_i)
            afe_bias_pkg::PH_SLEEP: phase_code = codes_i[5:4];
            afe_bias_pkg::PH_SECOND: phase_code = codes_i[3:2];
            afe_bias_pkg::PH_FIRST: phase_code = codes_i[1:0];
            default: phase_code = codes_i[1:0];
        endcase
    end
    assign cath_o = override_i ? phase_code : legacy_code;
    // anode follows cathode asleep, else fixed 1.3 V
    assign anode_o = (phase_i == afe_bias_pkg::PH_SLEEP) ? cath_o
                     : afe_bias_pkg::CODE_1V3;
endmodule : afe_bias_sel

// ==== rtl/afe_global_bias_config.sv ====
// global bias, powerdown and integration configuration bank
//
// What this block does
// - legacy bit 9 low gives 1.3 V cathode, high gives 1.8 V.
// - powerdown field 0x38 turns off channels two to four; 0 keeps all on.
// - second slot integrates four channels when bit 15 low, one when high.
// - first slot integrates four channels when bit 14 low, one when high.
// - asleep with override, bits 13:12 pick cathode: 1.8,1.3,1.55,0.0 V.
// - asleep, anode tracks cathode voltage.
// - in second slot with override, bits 11:10 pick cathode bias.
// - in second slot, anode stays at 1.3 V.
// - in first slot with override, bits 9:8 pick cathode bias.
// - in first slot, anode stays at 1.3 V.
// - override low uses legacy bit; high uses the three phase fields.
`timescale 1ns/100ps
module afe_global_bias_config (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // register port
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] addr_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] rdata_o,
    output logic rvalid_o,
    // phase from slot sequencer
    input wire logic sleep_i,
    input wire logic first_slot_i,
    input wire logic second_slot_i,
    // analog and sequencer controls
    output logic [1:0] cathode_code_o,
    output logic [1:0] anode_code_o,
    output logic [5:0] channel_pwrdn_sel_o,
    output logic [3:0] chan_on_o,
    output logic first_slot_one_channel_integ_o,
    output logic second_slot_one_channel_integ_o
);
    logic [15:0] bias_power;
    logic [15:0] override_reg;
    logic [2:0] phase;
    logic [1:0] cath;
    logic [1:0] anode;
    logic hit_bp;
    logic hit_ov;
    logic [15:0] next_rdata;
    logic [5:0] pwrdn;
    logic ov_en;
    logic legacy;

    assign hit_bp = addr_i == afe_bias_pkg::BIAS_POWER_ADDR;
    assign hit_ov = addr_i == afe_bias_pkg::OVERRIDE_ADDR;

    afe_bias_reg16 #(
        .RST_VAL(afe_bias_pkg::BIAS_POWER_RST)
    ) u_bias_power (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .wr_i(wr_i && hit_bp),
        .wdata_i(wdata_i),
        .q_o(bias_power)
    );

    afe_bias_reg16 #(
        .RST_VAL(afe_bias_pkg::OVERRIDE_RST)
    ) u_override (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .wr_i(wr_i && hit_ov),
        .wdata_i(wdata_i),
        .q_o(override_reg)
    );

    // sleep wins, then second slot, else first slot
    assign phase = sleep_i ? afe_bias_pkg::PH_SLEEP
                 : second_slot_i ? afe_bias_pkg::PH_SECOND
                 : afe_bias_pkg::PH_FIRST;

    afe_bias_sel u_sel (
        .phase_i(phase),
        .legacy_i(bias_power[afe_bias_pkg::LEGACY_CATH_BIT]),
        .override_i(override_reg[afe_bias_pkg::OVERRIDE_EN_BIT]),
        .codes_i(override_reg[13:8]),
        .cath_o(cath),
        .anode_o(anode)
    );

    assign pwrdn = bias_power[afe_bias_pkg::PWRDN_LSB +: 6];
    assign ov_en = override_reg[afe_bias_pkg::OVERRIDE_EN_BIT];
    assign legacy = bias_power[afe_bias_pkg::LEGACY_CATH_BIT];

    // full readback of stored words, unmapped reads zero
    assign next_rdata = hit_bp ? bias_power
                      : hit_ov ? override_reg : 16'h0000;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rdata_o <= 16'h0000;
            rvalid_o <= 1'b0;
        end else begin
            rdata_o <= rd_i ? next_rdata : rdata_o;
            rvalid_o <= rd_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            cathode_code_o <= afe_bias_pkg::CODE_1V3;
            anode_code_o <= afe_bias_pkg::CODE_1V3;
            channel_pwrdn_sel_o <= afe_bias_pkg::PWRDN_NONE;
            chan_on_o <= 4'hf;
            first_slot_one_channel_integ_o <= 1'b0;
            second_slot_one_channel_integ_o <= 1'b0;
        end else begin
            cathode_code_o <= cath;
            anode_code_o <= anode;
            channel_pwrdn_sel_o <= pwrdn;
            chan_on_o <= {~pwrdn[5], ~pwrdn[4], ~pwrdn[3], 1'b1};
            first_slot_one_channel_integ_o <=
                override_reg[afe_bias_pkg::FIRST_ONE_CH_BIT];
            second_slot_one_channel_integ_o <=
                override_reg[afe_bias_pkg::SECOND_ONE_CH_BIT];
        end
    end

    // checks: legacy cathode bit
    AST_LEGACY_CATH: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        !ov_en && legacy |=> cathode_code_o == afe_bias_pkg::CODE_1V8)
        else $error("legacy high cathode wrong");

    AST_LEGACY_LOW: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        !ov_en && !legacy |=> cathode_code_o == afe_bias_pkg::CODE_1V3)
        else $error("legacy low cathode wrong");

    // checks: channel powerdown
    AST_PWRDN_ALL: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        pwrdn == afe_bias_pkg::PWRDN_CH234 |=> chan_on_o == 4'h1)
        else $error("channels two to four not off");

    AST_PWRDN_NONE: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        pwrdn == afe_bias_pkg::PWRDN_NONE |=> chan_on_o == 4'hf)
        else $error("channels not all on");

    AST_PWRDN_COPY: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        1'b1 |=> channel_pwrdn_sel_o == $past(bias_power[8:3]))
        else $error("powerdown field copy wrong");

    AST_CH1_ON: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        1'b1 |=> chan_on_o[0])
        else $error("channel one off");

    // checks: integration channel select
    AST_SECOND_INT: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        override_reg[15] |=> second_slot_one_channel_integ_o)
        else $error("second slot single integ wrong");

    AST_SECOND_ALL: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        !override_reg[15] |=> !second_slot_one_channel_integ_o)
        else $error("second slot four channel integ wrong");

    AST_FIRST_INT: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        override_reg[14] |=> first_slot_one_channel_integ_o)
        else $error("first slot single integ wrong");

    AST_FIRST_ALL: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        !override_reg[14] |=> !first_slot_one_channel_integ_o)
        else $error("first slot four channel integ wrong");

    // checks: sleep phase
    AST_SLEEP_CODE: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        sleep_i && ov_en |=>
        cathode_code_o == $past(override_reg[13:12]))
        else $error("sleep cathode wrong");

    AST_SLEEP_ZERO: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        sleep_i && ov_en && override_reg[13:12] == afe_bias_pkg::CODE_0V0
        |=> cathode_code_o == afe_bias_pkg::CODE_0V0)
        else $error("sleep zero volt cathode wrong");

    AST_SLEEP_ANODE: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        sleep_i |=> anode_code_o == cathode_code_o)
        else $error("sleep anode differs");

    AST_SLEEP_ANODE_LEG: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        sleep_i && !ov_en |=> anode_code_o == ($past(legacy)
        ? afe_bias_pkg::CODE_1V8 : afe_bias_pkg::CODE_1V3))
        else $error("sleep legacy anode wrong");

    // checks: second slot phase
    AST_SECOND_CODE: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        !sleep_i && second_slot_i && ov_en |=>
        cathode_code_o == $past(override_reg[11:10]))
        else $error("second slot cathode wrong");

    AST_SECOND_ZERO: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        !sleep_i && second_slot_i && ov_en &&
        override_reg[11:10] == afe_bias_pkg::CODE_0V0
        |=> cathode_code_o == afe_bias_pkg::CODE_0V0)
        else $error("second slot zero volt cathode wrong");

    AST_SECOND_ANODE: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        !sleep_i && second_slot_i |=>
        anode_code_o == afe_bias_pkg::CODE_1V3)
        else $error("second slot anode not 1.3 V");

    // checks: first slot phase
    AST_FIRST_CODE: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        !sleep_i && !second_slot_i && ov_en |=>
        cathode_code_o == $past(override_reg[9:8]))
        else $error("first slot cathode wrong");

    AST_FIRST_PIN: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        first_slot_i && !sleep_i && !second_slot_i && ov_en |=>
        cathode_code_o == $past(override_reg[9:8]))
        else $error("first slot pin cathode wrong");

    AST_FIRST_ANODE: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        !sleep_i && !second_slot_i |=>
        anode_code_o == afe_bias_pkg::CODE_1V3)
        else $error("first slot anode not 1.3 V");

    // checks: override against legacy bit
    AST_OVR_IGNORE: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        sleep_i && ov_en && legacy &&
        override_reg[13:12] == afe_bias_pkg::CODE_1V3
        |=> cathode_code_o == afe_bias_pkg::CODE_1V3)
        else $error("override did not mask legacy bit");

    AST_NO_OVR_SLOT: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        !ov_en && !sleep_i |=> cathode_code_o == ($past(legacy)
        ? afe_bias_pkg::CODE_1V8 : afe_bias_pkg::CODE_1V3))
        else $error("slot legacy cathode wrong");

    // checks: register port and cathode output register
    AST_RVALID: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        rd_i |=> rvalid_o)
        else $error("read valid missing");

    AST_RVALID_LOW: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        !rd_i |=> !rvalid_o)
        else $error("read valid without read");

    AST_RD_BP: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        rd_i && hit_bp |=> rdata_o == $past(bias_power))
        else $error("bias power readback wrong");

    AST_RD_OV: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        rd_i && hit_ov |=> rdata_o == $past(override_reg))
        else $error("override readback wrong");

    AST_RD_UNMAPPED: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        rd_i && !hit_bp && !hit_ov |=> rdata_o == 16'h0000)
        else $error("unmapped read not zero");

    AST_RD_HOLD: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        !rd_i |=> $stable(rdata_o))
        else $error("read data moved without read");

    AST_WR_BP: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        wr_i && hit_bp |=> bias_power == $past(wdata_i))
        else $error("bias power write lost");

    AST_WR_OV: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        wr_i && hit_ov |=> override_reg == $past(wdata_i))
        else $error("override write lost");

    AST_KEEP_BP: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        !(wr_i && hit_bp) |=> $stable(bias_power))
        else $error("bias power changed without write");

    AST_KEEP_OV: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        !(wr_i && hit_ov) |=> $stable(override_reg))
        else $error("override changed without write");

    AST_CATH_SETTLED: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        1'b1 |=> cathode_code_o == $past(cath))
        else $error("cathode output not registered");
endmodule : afe_global_bias_config

// ==== test/tb_top.sv ====
// self-checking bench for the global bias configuration bank
`timescale 1ns/100ps
module tb_top;
    typedef struct packed {
        logic [2:0] ph;
        logic [15:0] r3c;
        logic [15:0] r54;
        logic [1:0] cath;
        logic [1:0] anode;
        logic [3:0] on;
        logic [1:0] ig;
    } row_t;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [15:0] wdata_i = 16'h0000;
    logic [2:0] ph = 3'h1;
    logic [15:0] rdata_o;
    logic rvalid_o;
    logic [1:0] cathode_code_o;
    logic [1:0] anode_code_o;
    logic [5:0] channel_pwrdn_sel_o;
    logic [3:0] chan_on_o;
    logic first_slot_one_channel_integ_o;
    logic second_slot_one_channel_integ_o;
    int num_errors = 0;
    int num_checks = 0;
    row_t rows [10];

    afe_global_bias_config afe_global_bias_config_inst (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .wr_i(wr_i), .rd_i(rd_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
        .rvalid_o(rvalid_o), .sleep_i(ph[2]), .second_slot_i(ph[1]),
        .first_slot_i(ph[0]), .cathode_code_o(cathode_code_o),
        .anode_code_o(anode_code_o),
        .channel_pwrdn_sel_o(channel_pwrdn_sel_o), .chan_on_o(chan_on_o),
        .first_slot_one_channel_integ_o(first_slot_one_channel_integ_o),
        .second_slot_one_channel_integ_o(second_slot_one_channel_integ_o)
    );

    initial begin
        forever #20 clk_i = ~clk_i;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i) #1;
        wr_i = 1'b1;
        addr_i = a;
        wdata_i = d;
        @(posedge clk_i) #1;
        wr_i = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_i) #1;
        rd_i = 1'b1;
        addr_i = a;
        @(posedge clk_i) #1;
        rd_i = 1'b0;
        chk(16'(rvalid_o), 16'h0001);
        chk(rdata_o, exp);
    endtask : rd

    task automatic test_done;
        if (num_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    initial begin
        #300000;
        num_errors++;
        test_done();
    end

    initial begin
        rows[0] = '{3'h1, 16'h3006, 16'h0020, 2'h1, 2'h1, 4'hf, 2'h0};
        rows[1] = '{3'h1, 16'h3206, 16'h0020, 2'h0, 2'h1, 4'hf, 2'h0};
        rows[2] = '{3'h1, 16'h31c6, 16'h4020, 2'h1, 2'h1, 4'h1, 2'h1};
        rows[3] = '{3'h2, 16'h3206, 16'h8ca0, 2'h3, 2'h1, 4'hf, 2'h2};
        rows[4] = '{3'h1, 16'h3206, 16'h02a0, 2'h2, 2'h1, 4'hf, 2'h0};
        rows[5] = '{3'h4, 16'h3006, 16'h00a0, 2'h0, 2'h0, 4'hf, 2'h0};
        rows[6] = '{3'h4, 16'h3006, 16'h10a0, 2'h1, 2'h1, 4'hf, 2'h0};
        rows[7] = '{3'h7, 16'h3006, 16'h26a0, 2'h2, 2'h2, 4'hf, 2'h0};
        rows[8] = '{3'h4, 16'h3006, 16'h30a0, 2'h3, 2'h3, 4'hf, 2'h0};
        rows[9] = '{3'h4, 16'h3206, 16'h0020, 2'h0, 2'h0, 4'hf, 2'h0};
        repeat (12) @(posedge clk_i);
        #1 rst_b_i = 1'b1;
        rd(8'h3c, 16'h3006);
        for (int i = 0; i < 10; i++) begin
            ph = rows[i].ph;
            wr(8'h3c, rows[i].r3c);
            wr(8'h54, rows[i].r54);
            repeat (2) @(posedge clk_i);
            #1;
            chk(16'(cathode_code_o), 16'(rows[i].cath));
            chk(16'(anode_code_o), 16'(rows[i].anode));
            chk(16'(chan_on_o), 16'(rows[i].on));
            chk(16'(channel_pwrdn_sel_o), 16'(rows[i].r3c[8:3]));
            chk(16'({second_slot_one_channel_integ_o,
                first_slot_one_channel_integ_o}), 16'(rows[i].ig));
            rd(8'h54, rows[i].r54);
        end
        // write and read together return the old word
        @(posedge clk_i) #1;
        wr_i = 1'b1;
        rd_i = 1'b1;
        wdata_i = 16'hffff;
        @(posedge clk_i) #1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        chk(rdata_o, 16'h0020);
        chk(16'(rvalid_o), 16'h0001);
        rd(8'h54, 16'hffff);
        // unmapped place
        wr(8'h40, 16'h1234);
        rd(8'h40, 16'h0000);
        rd(8'h3c, 16'h3206);
        // second reset mid-run
        @(posedge clk_i) #1 rst_b_i = 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        chk(16'(cathode_code_o), 16'h0001);
        chk(16'(chan_on_o), 16'h000f);
        chk(16'(anode_code_o), 16'h0001);
        chk(16'(channel_pwrdn_sel_o), 16'h0000);
        chk(16'(rvalid_o), 16'h0000);
        chk(rdata_o, 16'h0000);
        rst_b_i = 1'b1;
        rd(8'h3c, 16'h3006);
        rd(8'h54, 16'h0020);
        test_done();
    end
endmodule : tb_top
